// file: core/carrier_presence_sequencer.v
// carrier presence sequencer: tracks a carrier past the head, drives conveyor and stopper
// assumes an apb master on pclk, and field/sense inputs asynchronous to pclk
//
// How it works
// RL1: carrier control with driven outputs only in modes 2, 4 and 6
// RL2: field flag is filtered by a counter so edge dwell does not chatter
// RL3: after next is acknowledged a queued job waits for the next arriving carrier
// RL4: outputs switch over when the carrier leaves, even without next
// RL5: scan mode, carrier loss during an active job aborts with error 01
// RL6: scan mode, a carrier passing unserved or without next flags error 02
// RL7: mode 4, entry pulse marks arrival even before the field is reached
// RL8: mode 4, exit pulse marks departure; field drops during a job are ignored
// RL9: host finishes each job before the carrier reaches the exit switch
// RL10: host leaves conveyor and stopper alone in carrier control modes
// RL11: modes 4 and 6, exit pulse during a job aborts with error 01
// RL12: mode 4, entry then exit without job or next gives error 02
// RL13: mode 6, outputs switch over at field detection
// RL14: mode 6, presence bit 8 holds from detection until the exit pulse
// RL15: mode 6, entry input stays a free input readable by the host
// RL16: mode 6, field loss during a job is tolerated until the exit pulse
// RL17: mode 6, second exit pulse after 2 s without job or next gives error 02
// RL18: after reset, self test then startup code 15h within 3 s
// RL19: host issues a reset command after the startup code
// RL20: first reset command scans about 200 ms before carrier control begins
// RL21: presence checking pauses while the fieldbus link is not healthy
// RL22: after first reset with no carrier, wait for a carrier or a job
// RL23: after first reset with a carrier, next sends the next job to the next carrier
// RL24: a carrier that backs out is treated like one that passed through
// RL25: scan mode, stopper switches back on 0.5 s after the carrier exits
`timescale 1ns/10ps
`include "presence_seq_defs.vh"
module carrier_presence_sequencer
#(
  parameter SELFTEST_CYC = `T_SELFTEST_MS * (`CLK_HZ / 1000) - 1,
  parameter SCAN_CYC     = `T_SCAN_MS * (`CLK_HZ / 1000),
  parameter REARM_CYC    = `T_REARM_MS * (`CLK_HZ / 1000),
  parameter EXIT2_CYC    = `T_EXIT2_MS * (`CLK_HZ / 1000) + 1,
  parameter HYST         = `HYST_CYC
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        field_detect,
  input  wire        entry_sense_input,
  input  wire        exit_sense_input,
  output reg         conveyor_output,
  output reg         stopper_output
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [2:0] fld_s_q;
  reg [2:0] ent_s_q;
  reg [2:0] ext_s_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fld_s_q <= 3'h0;
      ent_s_q <= 3'h0;
      ext_s_q <= 3'h0;
    end
    else
    begin
      fld_s_q <= {fld_s_q[1:0], field_detect};
      ent_s_q <= {ent_s_q[1:0], entry_sense_input};
      ext_s_q <= {ext_s_q[1:0], exit_sense_input};
    end
  end
  // the third stage serves only the edge detectors
  wire fld_raw   = fld_s_q[1];
  wire entry_lvl = ent_s_q[1];
  wire exit_lvl  = ext_s_q[1];
  wire entry_p   = ent_s_q[1] & ~ent_s_q[2];
  wire exit_p    = ext_s_q[1] & ~ext_s_q[2];

  // ----------------------------------------
  // registers and apb decode
  // ----------------------------------------
  reg  [5:0]  ctrl_q;
  reg  [7:0]  err_q;
  reg         bad_q;
  wire [2:0]  mode   = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire        bus_ok = ctrl_q[`CTRL_BUS_OK];
  wire        ctl_on = (mode == `MODE_SCAN) || (mode == `MODE_TWO_IN) || (mode == `MODE_ONE_IN); // RL1
  wire        acc    = psel & penable & pready;
  wire        wr_ctl = acc & pwrite & (paddr == `OFS_CTRL);
  wire        wr_cmd = acc & pwrite & (paddr == `OFS_CMD);
  wire        rd_st  = acc & ~pwrite & (paddr == `OFS_STATUS);
  wire        mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_CMD) ||
                       (paddr == `OFS_STATUS) || (paddr == `OFS_IO);
  wire        c_rst  = wr_cmd & pwdata[`CMD_RESET];
  wire        c_job  = wr_cmd & pwdata[`CMD_JOB];
  wire        c_next = wr_cmd & pwdata[`CMD_NEXT];
  wire        c_done = wr_cmd & pwdata[`CMD_DONE];

  // ----------------------------------------
  // field hysteresis filter
  // ----------------------------------------
  reg [7:0] hcnt_q;
  reg       fld_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hcnt_q <= 8'h00;
      fld_q  <= 1'b0;
    end
    else if (fld_raw == fld_q)
      hcnt_q <= 8'h00;
    else if (hcnt_q == HYST[7:0] - 8'h01)
    begin
      hcnt_q <= 8'h00;
      fld_q  <= fld_raw; // RL2
    end
    else
      hcnt_q <= hcnt_q + 8'h01;
  end
  reg fld_d1_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fld_d1_q <= 1'b0;
    else
      fld_d1_q <= fld_q;
  end
  wire fld_rise = fld_q & ~fld_d1_q;
  wire fld_fall = ~fld_q & fld_d1_q;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  localparam ST_TEST = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_SCAN = 3'h2;
  localparam ST_RUN  = 3'h3;
  reg  [2:0]  st_q;
  reg  [27:0] tmr_q;
  reg  [27:0] rearm_q;
  reg  [27:0] ex2_q;
  reg         pres_q;
  reg         act_q;
  reg         que_q;
  reg         nack_q;
  reg         served_q;
  reg         ended_q;
  reg         ex_seen_q;
  reg         pend_q;
  wire        live   = (st_q == ST_RUN) & bus_ok; // RL21
  // departure and arrival events per mode
  wire        arrive = live & (mode == `MODE_TWO_IN ? entry_p : fld_rise); // RL7 RL13
  wire        depart = live & ((mode == `MODE_TWO_IN || mode == `MODE_ONE_IN) ? exit_p : fld_fall); // RL8 RL14 RL16 RL24
  wire        unserved = ~served_q | ~ended_q;
  wire        ex2_ok   = (mode != `MODE_ONE_IN) | ~ex_seen_q | (ex2_q == 28'h0);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q      <= ST_TEST;
      tmr_q     <= 28'h0;
      rearm_q   <= 28'h0;
      ex2_q     <= 28'h0;
      pres_q    <= 1'b0;
      act_q     <= 1'b0;
      que_q     <= 1'b0;
      nack_q    <= 1'b0;
      served_q  <= 1'b0;
      ended_q   <= 1'b0;
      ex_seen_q <= 1'b0;
      pend_q    <= 1'b0;
      err_q     <= `ERR_NONE;
      bad_q     <= 1'b0;
      conveyor_output <= 1'b0;
      stopper_output  <= 1'b0;
    end
    else
    begin
      if (rd_st & pend_q)
        pend_q <= 1'b0;
      if (ex2_q != 28'h0)
        ex2_q <= ex2_q - 28'h1;
      case (st_q)
        ST_TEST:
        begin
          tmr_q <= tmr_q + 28'h1;
          if (tmr_q == SELFTEST_CYC[27:0])
          begin
            err_q <= `ERR_STARTUP; // RL18
            st_q  <= ST_WAIT;
          end
        end
        ST_WAIT:
          if (c_rst) // RL19
          begin
            st_q  <= ST_SCAN;
            tmr_q <= 28'h0;
            err_q <= `ERR_NONE;
          end
        ST_SCAN:
        begin
          // first reset lasts the scan window before outputs are handed over
          tmr_q <= tmr_q + 28'h1;
          if (tmr_q == SCAN_CYC[27:0] - 28'h1) // RL20
          begin
            st_q   <= ST_RUN;
            pres_q <= fld_q & ctrl_q[`CTRL_SCAN_VAL];
            served_q <= 1'b0;
            ended_q  <= 1'b0;
            conveyor_output <= ctl_on & ~(fld_q & ctrl_q[`CTRL_SCAN_VAL]);
            stopper_output  <= ctl_on & ~(fld_q & ctrl_q[`CTRL_SCAN_VAL]);
          end
        end
        ST_RUN:
        begin
          if (c_rst)
          begin
            act_q  <= 1'b0;
            que_q  <= 1'b0;
            nack_q <= 1'b0;
            bad_q  <= 1'b0;
            err_q  <= `ERR_NONE;
          end
          if (c_job)
          begin
            // job waits in the queue while next is acknowledged or no carrier is here
            if (nack_q | ~pres_q)
              que_q <= 1'b1; // RL3 RL22 RL23
            else
              act_q <= 1'b1;
            served_q <= served_q | ~nack_q;
            bad_q    <= 1'b0;
            if (pend_q)
              pend_q <= 1'b0;
          end
          if (c_done)
          begin
            act_q <= 1'b0;
          end
          if (c_next & ctl_on & pres_q)
          begin
            nack_q  <= 1'b1;
            ended_q <= 1'b1;
            served_q <= 1'b1;
            conveyor_output <= 1'b1;
            stopper_output  <= 1'b0;
          end
          if (rearm_q != 28'h0)
          begin
            rearm_q <= rearm_q - 28'h1;
            if (rearm_q == 28'h1)
              stopper_output <= 1'b1; // RL25
          end
          if (arrive & ~pres_q)
          begin
            pres_q   <= 1'b1;
            nack_q   <= 1'b0;
            ended_q  <= 1'b0;
            served_q <= que_q;
            rearm_q  <= 28'h0;
            if (que_q)
            begin
              act_q <= 1'b1; // RL3
              que_q <= 1'b0;
            end
            if (ctl_on)
            begin
              conveyor_output <= 1'b0; // RL13
              stopper_output  <= 1'b0;
            end
          end
          if (depart & (pres_q | mode == `MODE_ONE_IN))
          begin
            pres_q <= 1'b0;
            ex_seen_q <= 1'b1;
            ex2_q  <= EXIT2_CYC[27:0];
            if (ctl_on)
            begin
              conveyor_output <= 1'b1; // RL4
              if (mode == `MODE_SCAN)
                rearm_q <= REARM_CYC[27:0];
              else
                stopper_output <= 1'b1;
            end
            if (ctl_on & (act_q & ~c_done))
            begin
              act_q  <= 1'b0; // RL5 RL11
              bad_q  <= 1'b1;
              err_q  <= `ERR_LOST;
              pend_q <= 1'b1;
            end
            else if (ctl_on & unserved & ex2_ok & (pres_q | ex_seen_q))
            begin
              err_q  <= `ERR_MISSED; // RL6 RL12 RL17
              pend_q <= 1'b1;
            end
          end
        end
        default:
          st_q <= ST_TEST;
      endcase
    end
  end

  // ----------------------------------------
  // control register and apb response
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= 6'h00;
    else if (wr_ctl)
      ctrl_q <= pwdata[5:0];
  end
  wire [15:0] stat = {st_q != ST_TEST, bus_ok, bad_q, nack_q, st_q == ST_RUN, que_q, act_q, pres_q, err_q};
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
      begin
        case (paddr)
          `OFS_CTRL:   prdata <= {26'h0, ctrl_q};
          `OFS_STATUS: prdata <= {16'h0, stat};
          // entry input is free to read in every mode
          `OFS_IO:     prdata <= {26'h0, stopper_output, conveyor_output, 1'b0, fld_q, exit_lvl, entry_lvl}; // RL15
          default:     prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

// file: core/presence_seq_defs.vh
// constants for the carrier presence sequencer: register map, fields, codes, times
// assumes a 32-bit apb slave at 25 mhz
`ifndef PRESENCE_SEQ_DEFS_VH
`define PRESENCE_SEQ_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL      12'h000
`define OFS_CMD       12'h004
`define OFS_STATUS    12'h008
`define OFS_IO        12'h00C
// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_BUS_OK   4
`define CTRL_SCAN_VAL 5
// ----------------------------------------
// command register bits (write one to issue)
// ----------------------------------------
`define CMD_RESET     0
`define CMD_JOB       1
`define CMD_NEXT      2
`define CMD_DONE      3
// ----------------------------------------
// status word fields
// ----------------------------------------
`define ST_ERR_LSB    0
`define ST_ERR_MSB    7
`define ST_PRESENT    8
`define ST_JOB_ACT    9
`define ST_JOB_QUE    10
`define ST_READY      11
`define ST_NEXT_ACK   12
`define ST_DATA_BAD   13
`define ST_LINKED     14
`define ST_STARTED    15
// ----------------------------------------
// modes and error codes
// ----------------------------------------
`define MODE_SCAN     3'h2
`define MODE_TWO_IN   3'h4
`define MODE_ONE_IN   3'h6
`define ERR_NONE      8'h00
`define ERR_LOST      8'h01
`define ERR_MISSED    8'h02
`define ERR_STARTUP   8'h15
// ----------------------------------------
// times (ms), field filter length (cycles) and clock
// ----------------------------------------
`define CLK_HZ        25000000
`define T_SELFTEST_MS 3000
`define T_SCAN_MS     200
`define T_REARM_MS    500
`define T_EXIT2_MS    2000
`define HYST_CYC      16
`endif

// file: tb/presence_seq_assertions.sv
// checker: apb answer and carrier output properties of the presence sequencer
// assumes apb per protocol; mode and link flag are taken from ctrl writes
`timescale 1ns/10ps
module presence_seq_assertions
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        field_detect,
  input wire        entry_sense_input,
  input wire        exit_sense_input,
  input wire        conveyor_output,
  input wire        stopper_output
);
  logic [2:0] mode_q;
  logic       bus_q;
  logic       live_q;
  wire        m4 = live_q && bus_q && mode_q == 3'h4;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // live only once scan ended: before that outputs sit at 0 whatever the inputs do
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= 3'h0;
      bus_q  <= 1'b0;
      live_q <= 1'b0;
    end
    else
    begin
      live_q <= live_q | conveyor_output | stopper_output;
      if (psel && penable && pready && pwrite && paddr == 12'h000)
      begin
        mode_q <= pwdata[2:0];
        bus_q  <= pwdata[4];
      end
    end
  end
  AST_PREADY_ACCESS: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  AST_UNMAPPED: assert property (psel && penable && paddr > 12'h00C |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (psel && penable && paddr <= 12'h00C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  AST_RESET_QUIET: assert property ($rose(presetn) |-> (!conveyor_output && !stopper_output) [*8])
    else $error("outputs active right after reset");
  AST_ENTRY4: assert property (m4 && $rose(entry_sense_input) |-> ##[1:6] !conveyor_output && !stopper_output)
    else $error("entry pulse did not stop carrier");
  AST_EXIT4: assert property (m4 && $rose(exit_sense_input) |-> ##[1:6] conveyor_output && stopper_output)
    else $error("exit pulse did not release carrier");
  AST_FIELD6: assert property (live_q && bus_q && mode_q == 3'h6 && $rose(field_detect) ##1 field_detect [*8]
    |-> ##[0:4] !conveyor_output && !stopper_output)
    else $error("field detect did not stop carrier");
  AST_REARM: assert property (mode_q == 3'h2 && $rose(conveyor_output) && !stopper_output |=> !stopper_output [*8])
    else $error("stopper back on too early");
  AST_HYST: assert property (live_q && mode_q == 3'h2 && !conveyor_output && !stopper_output && $fell(field_detect)
    |=> (!conveyor_output && !stopper_output) [*3])
    else $error("presence dropped without filtering");
endmodule
bind carrier_presence_sequencer presence_seq_assertions i_presence_seq_assertions (
  .pclk              (pclk),
  .presetn           (presetn),
  .psel              (psel),
  .penable           (penable),
  .pwrite            (pwrite),
  .paddr             (paddr),
  .pwdata            (pwdata),
  .prdata            (prdata),
  .pready            (pready),
  .pslverr           (pslverr),
  .field_detect      (field_detect),
  .entry_sense_input (entry_sense_input),
  .exit_sense_input  (exit_sense_input),
  .conveyor_output   (conveyor_output),
  .stopper_output    (stopper_output)
);

// file: tb/field_side.sv
// partner: carrier on the conveyor seen by head field and proximity switches
// assumes calls from the bench right after a rising pclk edge
`timescale 1ns/10ps
module field_side
(
  input wire  pclk,
  output logic field_detect,
  output logic entry_sense_input,
  output logic exit_sense_input
);
  initial
  begin
    field_detect      = 1'b0;
    entry_sense_input = 1'b0;
    exit_sense_input  = 1'b0;
  end
  // waits past the two sync flops and the field filter before returning
  task car(input logic on);
    field_detect <= on;
    repeat (12) @(posedge pclk);
  endtask
  task glitch(input int w);
    field_detect <= 1'b0;
    repeat (w) @(posedge pclk);
    field_detect <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask
  // switches give clean pulses of a few cycles, never shorter than a sync stage
  task pulse(input logic ex);
    if (ex)
      exit_sense_input <= 1'b1;
    else
      entry_sense_input <= 1'b1;
    repeat ($urandom_range(2, 5)) @(posedge pclk);
    exit_sense_input  <= 1'b0;
    entry_sense_input <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask
endmodule

// file: tb/carrier_presence_sequencer_tb.sv
// bench: drives apb and the field side, compares status and outputs
// assumes short counts set below in place of the long times
`timescale 1ns/10ps
module carrier_presence_sequencer_tb;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire         field_detect;
  wire         entry_sense_input;
  wire         exit_sense_input;
  logic        conveyor_output;
  logic        stopper_output;
  logic [31:0] rdata;
  logic        rerr;
  int          n_fail = 0;
  int          checked = 0;
  int          n;
  always #20 pclk = ~pclk;
  carrier_presence_sequencer #(.SELFTEST_CYC(50), .SCAN_CYC(20), .REARM_CYC(30), .EXIT2_CYC(40), .HYST(4))
    i_carrier_presence_sequencer (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .field_detect      (field_detect),
    .entry_sense_input (entry_sense_input),
    .exit_sense_input  (exit_sense_input),
    .conveyor_output   (conveyor_output),
    .stopper_output    (stopper_output)
  );
  field_side i_field_side (.pclk(pclk), .field_detect(field_detect), .entry_sense_input(entry_sense_input),
    .exit_sense_input(exit_sense_input));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task wrap_up;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      n_fail++;
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task st;
    apb(1'b0, 12'h008, 32'h0);
  endtask
  task outs(input logic [1:0] e);
    chk("outputs", {30'h0, e}, {30'h0, conveyor_output, stopper_output});
  endtask
  // reset pulse, then poll until the startup code shows
  task boot;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do
    begin
      st();
      n++;
    end
    while (rdata[7:0] !== 8'h15 && n < 20);
    chk("startup", 32'h15, {24'h0, rdata[7:0]});
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 12'h000;
    pwdata  <= 32'h0;
    void'($urandom(32'h2917));
    boot();
    apb(1'b1, 12'h000, 32'h32);
    apb(1'b1, 12'h004, 32'h1);
    outs(2'b00);
    repeat (30) @(posedge pclk);
    outs(2'b11);
    i_field_side.car(1'b1);
    outs(2'b00);
    i_field_side.glitch($urandom_range(1, 2));
    st();
    chk("present", 32'h1, {31'h0, rdata[8]});
    apb(1'b1, 12'h004, 32'h2);
    i_field_side.car(1'b0);
    st();
    chk("lost", 32'h2001, {18'h0, rdata[13], 5'h0, rdata[7:0]});
    outs(2'b10);
    repeat (30) @(posedge pclk);
    outs(2'b11);
    apb(1'b1, 12'h004, 32'h1);
    i_field_side.car(1'b1);
    i_field_side.car(1'b0);
    apb(1'b1, 12'h004, 32'h2);
    st();
    chk("missed", 32'h2, {24'h0, rdata[7:0]});
    apb(1'b1, 12'h000, 32'h34);
    apb(1'b1, 12'h004, 32'h1);
    i_field_side.pulse(1'b0);
    outs(2'b00);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h004, 32'h8);
    apb(1'b1, 12'h004, 32'h4);
    apb(1'b1, 12'h004, 32'h2);
    st();
    chk("queued", 32'h3, {30'h0, rdata[12], rdata[10]});
    i_field_side.pulse(1'b1);
    st();
    chk("clean exit", 32'h0, {24'h0, rdata[7:0]});
    i_field_side.pulse(1'b0);
    st();
    chk("job on new", 32'h1, {31'h0, rdata[9]});
    i_field_side.pulse(1'b1);
    st();
    chk("abort", 32'h1, {24'h0, rdata[7:0]});
    apb(1'b1, 12'h004, 32'h1);
    i_field_side.pulse(1'b0);
    i_field_side.pulse(1'b1);
    apb(1'b1, 12'h004, 32'h2);
    st();
    chk("unserved", 32'h2, {24'h0, rdata[7:0]});
    apb(1'b1, 12'h000, 32'h36);
    apb(1'b1, 12'h004, 32'h1);
    i_field_side.car(1'b1);
    outs(2'b00);
    i_field_side.car(1'b0);
    st();
    chk("held", 32'h1, {31'h0, rdata[8]});
    i_field_side.entry_sense_input <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h00C, 32'h0);
    chk("free input", 32'h1, {31'h0, rdata[0]});
    i_field_side.entry_sense_input <= 1'b0;
    i_field_side.pulse(1'b1);
    apb(1'b1, 12'h004, 32'h2);
    st();
    chk("exit6", 32'h2, {23'h0, rdata[8:0]});
    apb(1'b1, 12'h000, 32'h26);
    apb(1'b1, 12'h004, 32'h1);
    i_field_side.car(1'b1);
    st();
    chk("link down", 32'h0, {31'h0, rdata[8]});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {rdata[30:0], rerr});
    // second reset in mid-run with a carrier already sitting in the field
    boot();
    apb(1'b1, 12'h000, 32'h32);
    apb(1'b1, 12'h004, 32'h1);
    repeat (30) @(posedge pclk);
    outs(2'b00);
    apb(1'b1, 12'h004, 32'h4);
    apb(1'b1, 12'h004, 32'h2);
    st();
    chk("next first", 32'h6, {29'h0, rdata[12], rdata[10], rdata[9]});
    outs(2'b10);
    wrap_up();
  end
endmodule
